// file: sfo_pkg.sv
// Purpose: constants and types for the sensor fault output select block
// Assumes: configuration words are 16 bits; nine fault comparators
// Notes: comparator grouping into internal and external is fixed here
package sfo_pkg;
  localparam int CFG_W = 16;
  localparam int ALARM_W = 16;
  localparam int COMP_N = 9;
  localparam int SYNC_STAGES = 2;

  // config word one fields
  localparam int CONFIG_WORD_ONE_INT_FAULT_LEVEL_SEL = 7;
  localparam int CONFIG_WORD_ONE_EXT_POL = 8;
  localparam int CONFIG_WORD_ONE_INT_EN = 9;
  localparam int CONFIG_WORD_ONE_EXT_EN = 10;

  // config word two fields
  localparam int CONFIG_WORD_TWO_DOUT_VAL = 7;
  localparam int CONFIG_WORD_TWO_DOUT_SEL = 8;

  localparam logic [CFG_W-1:0] CONFIG_WORD_ONE_RST = 16'h0000;
  localparam logic [CFG_W-1:0] CONFIG_WORD_TWO_RST = 16'h0000;
  localparam logic [COMP_N-1:0] ALARM_RST = 9'h000;

  // comparator grouping: low six bits external, upper three internal
  localparam logic [COMP_N-1:0] EXT_MASK = 9'h03F;
  localparam logic [COMP_N-1:0] INT_MASK = 9'h1C0;

  localparam logic FAULT_LVL_HIGH = 1'b1;
  localparam logic DOUT_SEL_OUT = 1'b1;

  // amplifier command, gray along linear -> limit -> fault
  typedef enum logic [2:0] {
    SFO_AMP_LINEAR = 3'h0,
    SFO_AMP_OVER_LIM = 3'h1,
    SFO_AMP_UNDER_LIM = 3'h3,
    SFO_AMP_FAULT_LOW = 3'h2,
    SFO_AMP_FAULT_RAIL = 3'h6,
    SFO_AMP_FAULT_CLAMP = 3'h7
  } sfo_amp_mode_e;
endpackage

// file: sfo_sync2.sv
// Purpose: two-flop synchroniser for the comparator levels
// Assumes: inputs are slow levels from analog comparators
// Notes: only the second stage may be read by logic
`timescale 1ns/100ps
module sfo_sync2 import sfo_pkg::*; #(
  parameter int W = COMP_N
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule

// file: sfo_alarm_hold.sv
// Purpose: alarm snapshot of the synchronised comparator results
// Assumes: output enable comes from logic on the same clock
// Notes: holding keeps the last enabled sample, so the value is pre-disable
`timescale 1ns/100ps
module sfo_alarm_hold import sfo_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // control and data
  input wire logic vout_enable,
  input wire logic [COMP_N-1:0] comp_sync,
  output logic [ALARM_W-1:0] fault_alarm_snapshot
);
  logic [COMP_N-1:0] alarm_ff;
  logic [COMP_N-1:0] nxt_alarm;

  assign nxt_alarm = vout_enable ? comp_sync : alarm_ff;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      alarm_ff <= ALARM_RST;
    end else begin
      alarm_ff <= nxt_alarm;
    end
  end

  // upper bits read as zero
  assign fault_alarm_snapshot = {{(ALARM_W-COMP_N){1'b0}}, alarm_ff};
endmodule

// file: sfo_fault_select.sv
// Purpose: fault flag grouping, fault level selection and shared pin control
// Assumes: config writes, otp load and limit selects come from logic on sys_clk
// Notes: comparator levels are synchronised, adding two cycles of latency
`timescale 1ns/100ps
module sfo_fault_select import sfo_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // fault comparators, asynchronous
  input wire logic [COMP_N-1:0] comp_async,
  // sensor output enable
  input wire logic vout_enable,
  // host configuration writes
  input wire logic config_word_one_wr,
  input wire logic [CFG_W-1:0] config_word_one_wdata,
  input wire logic config_word_two_wr,
  input wire logic [CFG_W-1:0] config_word_two_wdata,
  // one-time memory load
  input wire logic otp_load,
  input wire logic [CFG_W-1:0] otp_config_word_one,
  input wire logic [CFG_W-1:0] otp_config_word_two,
  // normal output path selects
  input wire logic over_lim_sel,
  input wire logic under_lim_sel,
  // readback
  output logic [CFG_W-1:0] config_word_one,
  output logic [CFG_W-1:0] config_word_two,
  output logic [ALARM_W-1:0] fault_alarm_snapshot,
  // amplifier command and flags
  output sfo_amp_mode_e amp_mode,
  output logic int_fault_flag,
  output logic ext_fault_flag,
  // shared digital output / clamp pin
  output logic dout_o,
  output logic dout_oe
);
  logic [CFG_W-1:0] config_word_one_ff;
  logic [CFG_W-1:0] config_word_two_ff;
  logic [CFG_W-1:0] nxt_config_word_one;
  logic [CFG_W-1:0] nxt_config_word_two;
  logic [COMP_N-1:0] comp_sync;
  logic int_flag_ff;
  logic ext_flag_ff;
  sfo_amp_mode_e amp_mode_ff;
  sfo_amp_mode_e nxt_amp_mode;

  // fault level to amplifier command; high level target depends on pin mode
  function automatic sfo_amp_mode_e lvl_mode(input logic lvl, input logic dsel);
    sfo_amp_mode_e m;
    m = SFO_AMP_FAULT_LOW;
    if (lvl == FAULT_LVL_HIGH) begin
      m = (dsel == DOUT_SEL_OUT) ? SFO_AMP_FAULT_RAIL : SFO_AMP_FAULT_CLAMP;
    end
    return m;
  endfunction

  sfo_sync2 #(.W(COMP_N)) u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .async_in(comp_async),
    .sync_out(comp_sync)
  );

  sfo_alarm_hold u_alarm (
    .sys_clk(sys_clk),
    .reset(reset),
    .vout_enable(vout_enable),
    .comp_sync(comp_sync),
    .fault_alarm_snapshot(fault_alarm_snapshot)
  );

  // configuration: a host write wins over an otp load in the same cycle
  assign nxt_config_word_one = config_word_one_wr ? config_word_one_wdata : (otp_load ? otp_config_word_one : config_word_one_ff);
  assign nxt_config_word_two = config_word_two_wr ? config_word_two_wdata : (otp_load ? otp_config_word_two : config_word_two_ff);

  // grouped flags
  wire int_any = |(comp_sync & INT_MASK);
  wire ext_any = |(comp_sync & EXT_MASK);
  wire ext_force = ext_any & config_word_one_ff[CONFIG_WORD_ONE_EXT_EN];
  wire int_force = int_any & config_word_one_ff[CONFIG_WORD_ONE_INT_EN];
  wire dsel = config_word_two_ff[CONFIG_WORD_TWO_DOUT_SEL];
  wire [2:0] ext_lvl_mode = lvl_mode(config_word_one_ff[CONFIG_WORD_ONE_EXT_POL], dsel);
  wire [2:0] int_lvl_mode = lvl_mode(config_word_one_ff[CONFIG_WORD_ONE_INT_FAULT_LEVEL_SEL], dsel);
  // over-scale wins if both limits are asserted at once
  wire [2:0] norm_mode = over_lim_sel ? SFO_AMP_OVER_LIM :
                         (under_lim_sel ? SFO_AMP_UNDER_LIM : SFO_AMP_LINEAR);

  // external first, then internal, then the normal path
  always_comb begin
    if (ext_force) begin
      nxt_amp_mode = sfo_amp_mode_e'(ext_lvl_mode);
    end else if (int_force) begin
      nxt_amp_mode = sfo_amp_mode_e'(int_lvl_mode);
    end else begin
      nxt_amp_mode = sfo_amp_mode_e'(norm_mode);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      config_word_one_ff <= CONFIG_WORD_ONE_RST;
      config_word_two_ff <= CONFIG_WORD_TWO_RST;
      int_flag_ff <= 1'b0;
      ext_flag_ff <= 1'b0;
      amp_mode_ff <= SFO_AMP_LINEAR;
    end else begin
      config_word_one_ff <= nxt_config_word_one;
      config_word_two_ff <= nxt_config_word_two;
      int_flag_ff <= int_any;
      ext_flag_ff <= ext_any;
      amp_mode_ff <= nxt_amp_mode;
    end
  end

  assign config_word_one = config_word_one_ff;
  assign config_word_two = config_word_two_ff;
  assign amp_mode = amp_mode_ff;
  assign int_fault_flag = int_flag_ff;
  assign ext_fault_flag = ext_flag_ff;
  // driver is off in clamp mode so the pin stays high impedance
  assign dout_oe = config_word_two_ff[CONFIG_WORD_TWO_DOUT_SEL];
  assign dout_o = config_word_two_ff[CONFIG_WORD_TWO_DOUT_SEL] & config_word_two_ff[CONFIG_WORD_TWO_DOUT_VAL];

  property p_alarm_follow;
    @(posedge sys_clk) disable iff (reset)
      vout_enable |=> fault_alarm_snapshot[COMP_N-1:0] == $past(comp_sync);
  endproperty
  a_alarm_follow: assert property (p_alarm_follow)
    else $error("alarm snapshot does not follow comparators");

  property p_alarm_freeze;
    @(posedge sys_clk) disable iff (reset)
      !vout_enable ##1 !vout_enable |-> $stable(fault_alarm_snapshot);
  endproperty
  a_alarm_freeze: assert property (p_alarm_freeze)
    else $error("alarm snapshot changed while output disabled");

  property p_alarm_upper_zero;
    @(posedge sys_clk) disable iff (reset)
      fault_alarm_snapshot[ALARM_W-1:COMP_N] == '0;
  endproperty
  a_alarm_upper_zero: assert property (p_alarm_upper_zero)
    else $error("alarm snapshot upper bits not zero");

  property p_flags_group;
    @(posedge sys_clk) disable iff (reset)
      ##1 (ext_fault_flag == |($past(comp_sync) & EXT_MASK)) &&
          (int_fault_flag == |($past(comp_sync) & INT_MASK));
  endproperty
  a_flags_group: assert property (p_flags_group)
    else $error("fault flag grouping wrong");

  property p_ext_disabled;
    @(posedge sys_clk) disable iff (reset)
      !config_word_one_ff[CONFIG_WORD_ONE_EXT_EN] && !int_force |=> amp_mode_ff == $past(norm_mode);
  endproperty
  a_ext_disabled: assert property (p_ext_disabled)
    else $error("fault forced while both groups disabled or idle");

  property p_int_force;
    @(posedge sys_clk) disable iff (reset)
      int_force && !ext_force && !config_word_one_ff[CONFIG_WORD_ONE_INT_FAULT_LEVEL_SEL]
      |=> amp_mode_ff == SFO_AMP_FAULT_LOW;
  endproperty
  a_int_force: assert property (p_int_force)
    else $error("internal low fault not forced");

  property p_high_target;
    @(posedge sys_clk) disable iff (reset)
      ext_force && config_word_one_ff[CONFIG_WORD_ONE_EXT_POL]
      |=> amp_mode_ff == ($past(dsel) ? SFO_AMP_FAULT_RAIL : SFO_AMP_FAULT_CLAMP);
  endproperty
  a_high_target: assert property (p_high_target)
    else $error("high fault target wrong");

  property p_ext_priority;
    @(posedge sys_clk) disable iff (reset)
      ext_force && int_force && !config_word_one_ff[CONFIG_WORD_ONE_EXT_POL] && config_word_one_ff[CONFIG_WORD_ONE_INT_FAULT_LEVEL_SEL]
      |=> amp_mode_ff == SFO_AMP_FAULT_LOW;
  endproperty
  a_ext_priority: assert property (p_ext_priority)
    else $error("external fault level not given priority");

  property p_pin_mode;
    @(posedge sys_clk) disable iff (reset)
      config_word_two_wr |=> dout_oe == $past(config_word_two_wdata[CONFIG_WORD_TWO_DOUT_SEL]) &&
                  dout_o == ($past(config_word_two_wdata[CONFIG_WORD_TWO_DOUT_SEL]) &
                             $past(config_word_two_wdata[CONFIG_WORD_TWO_DOUT_VAL]));
  endproperty
  a_pin_mode: assert property (p_pin_mode)
    else $error("shared pin does not follow host write");

  property p_reset_pin_off;
    @(posedge sys_clk) disable iff (reset)
      $fell(reset) |-> !dout_oe && !dout_o && amp_mode_ff == SFO_AMP_LINEAR;
  endproperty
  a_reset_pin_off: assert property (p_reset_pin_off)
    else $error("shared pin driven after reset");

  // configuration words: host write, otp load and hold between them
  property p_config_word_one_write;
    @(posedge sys_clk) disable iff (reset)
      config_word_one_wr |=> config_word_one == $past(config_word_one_wdata);
  endproperty
  a_config_word_one_write: assert property (p_config_word_one_write)
    else $error("config word one not loaded by host write");

  property p_otp_load;
    @(posedge sys_clk) disable iff (reset)
      otp_load && !config_word_two_wr |=> config_word_two == $past(otp_config_word_two);
  endproperty
  a_otp_load: assert property (p_otp_load)
    else $error("config word two not loaded from otp");

  property p_cfg_hold;
    @(posedge sys_clk) disable iff (reset)
      !config_word_one_wr && !otp_load |=> $stable(config_word_one);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("config word one changed without a load");

  // the normal path when no group forces a fault
  property p_no_force_pass;
    @(posedge sys_clk) disable iff (reset)
      !int_force && !ext_force |=> amp_mode_ff == $past(norm_mode);
  endproperty
  a_no_force_pass: assert property (p_no_force_pass)
    else $error("normal command not passed through");

  property p_int_gate;
    @(posedge sys_clk) disable iff (reset)
      !config_word_one_ff[CONFIG_WORD_ONE_INT_EN] && !ext_force |=> amp_mode_ff == $past(norm_mode);
  endproperty
  a_int_gate: assert property (p_int_gate)
    else $error("internal fault forced while disabled");

  property p_over_pass;
    @(posedge sys_clk) disable iff (reset)
      !ext_force && !int_force && over_lim_sel |=> amp_mode_ff == SFO_AMP_OVER_LIM;
  endproperty
  a_over_pass: assert property (p_over_pass)
    else $error("over-scale limit not passed through");

  property p_under_pass;
    @(posedge sys_clk) disable iff (reset)
      !ext_force && !int_force && !over_lim_sel && under_lim_sel
      |=> amp_mode_ff == SFO_AMP_UNDER_LIM;
  endproperty
  a_under_pass: assert property (p_under_pass)
    else $error("under-scale limit not passed through");

  // forced faults: levels and targets
  property p_ext_low;
    @(posedge sys_clk) disable iff (reset)
      ext_force && !config_word_one_ff[CONFIG_WORD_ONE_EXT_POL] |=> amp_mode_ff == SFO_AMP_FAULT_LOW;
  endproperty
  a_ext_low: assert property (p_ext_low)
    else $error("external low fault not forced to ground");

  property p_int_high;
    @(posedge sys_clk) disable iff (reset)
      int_force && !ext_force && config_word_one_ff[CONFIG_WORD_ONE_INT_FAULT_LEVEL_SEL]
      |=> amp_mode_ff == ($past(dsel) ? SFO_AMP_FAULT_RAIL : SFO_AMP_FAULT_CLAMP);
  endproperty
  a_int_high: assert property (p_int_high)
    else $error("internal high fault target wrong");

  property p_fault_override;
    @(posedge sys_clk) disable iff (reset)
      ext_force || int_force
      |=> amp_mode_ff inside {SFO_AMP_FAULT_LOW, SFO_AMP_FAULT_RAIL, SFO_AMP_FAULT_CLAMP};
  endproperty
  a_fault_override: assert property (p_fault_override)
    else $error("limit or linear command not overridden by fault");

  property p_ext_high_wins;
    @(posedge sys_clk) disable iff (reset)
      ext_force && int_force && config_word_one_ff[CONFIG_WORD_ONE_EXT_POL] && !config_word_one_ff[CONFIG_WORD_ONE_INT_FAULT_LEVEL_SEL]
      |=> amp_mode_ff != SFO_AMP_FAULT_LOW;
  endproperty
  a_ext_high_wins: assert property (p_ext_high_wins)
    else $error("internal low level applied over external high");

  // shared pin: driver off in clamp mode, value bit in output mode
  property p_pin_off_clamp;
    @(posedge sys_clk) disable iff (reset)
      !config_word_two_ff[CONFIG_WORD_TWO_DOUT_SEL] |-> !dout_oe && !dout_o;
  endproperty
  a_pin_off_clamp: assert property (p_pin_off_clamp)
    else $error("shared pin driven in clamp mode");

  property p_pin_value;
    @(posedge sys_clk) disable iff (reset)
      dout_oe |-> dout_o == config_word_two_ff[CONFIG_WORD_TWO_DOUT_VAL];
  endproperty
  a_pin_value: assert property (p_pin_value)
    else $error("shared pin level differs from drive bit");

  // alarm snapshot picks up the live comparators again after re-enable
  property p_alarm_reenable;
    @(posedge sys_clk) disable iff (reset)
      $rose(vout_enable) |=> fault_alarm_snapshot[COMP_N-1:0] == $past(comp_sync);
  endproperty
  a_alarm_reenable: assert property (p_alarm_reenable)
    else $error("alarm snapshot stale after re-enable");
endmodule

// file: sfo_amp_model.sv
// Purpose: output amplifier and shared pin level model
// Assumes: a clamp divider holds the pin high when undriven
// Notes: pin level resolved from the design's drive enable
`timescale 1ns/100ps
module sfo_amp_model import sfo_pkg::*; (
  // design side
  input wire logic dout_o,
  input wire logic dout_oe,
  input wire sfo_amp_mode_e amp_mode,
  // pin and output
  output logic pin_lvl,
  output logic [1:0] vout_kind
);
  // undriven pin sits at the divider level, never a stale value
  assign pin_lvl = dout_oe ? dout_o : 1'b1;
  // 0 ground, 1 rail, 2 clamp, 3 linear or limited
  assign vout_kind = (amp_mode == SFO_AMP_FAULT_LOW) ? 2'h0 :
    (amp_mode == SFO_AMP_FAULT_RAIL) ? 2'h1 :
    (amp_mode == SFO_AMP_FAULT_CLAMP) ? 2'h2 : 2'h3;
endmodule

// file: sensor_fault_output_select_bench.sv
// Purpose: self-checking bench for the fault output select block
// Assumes: outputs settle within four cycles of a comparator change
// Notes: limits ride on the level bits so all four mixes are seen
`timescale 1ns/100ps
module sensor_fault_output_select_bench import sfo_pkg::*; ();
  // stimulus
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [COMP_N-1:0] comp_async = '0;
  logic vout_enable = 1'b1;
  logic config_word_one_wr = 1'b0;
  logic config_word_two_wr = 1'b0;
  logic otp_load = 1'b0;
  logic [CFG_W-1:0] config_word_one_wdata = '0;
  logic [CFG_W-1:0] config_word_two_wdata = '0;
  logic [CFG_W-1:0] otp_config_word_one = '0;
  logic [CFG_W-1:0] otp_config_word_two = '0;
  logic over_lim_sel = 1'b0;
  logic under_lim_sel = 1'b0;
  // observed
  logic [CFG_W-1:0] config_word_one;
  logic [CFG_W-1:0] config_word_two;
  logic [ALARM_W-1:0] fault_alarm_snapshot;
  sfo_amp_mode_e amp_mode;
  logic int_fault_flag;
  logic ext_fault_flag;
  logic dout_o;
  logic dout_oe;
  logic pin_lvl;
  logic [1:0] vout_kind;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;

  sfo_fault_select dut_u (.sys_clk(sys_clk), .reset(reset), .comp_async(comp_async),
    .vout_enable(vout_enable), .config_word_one_wr(config_word_one_wr), .config_word_one_wdata(config_word_one_wdata),
    .config_word_two_wr(config_word_two_wr), .config_word_two_wdata(config_word_two_wdata), .otp_load(otp_load),
    .otp_config_word_one(otp_config_word_one), .otp_config_word_two(otp_config_word_two), .over_lim_sel(over_lim_sel),
    .under_lim_sel(under_lim_sel), .config_word_one(config_word_one),
    .config_word_two(config_word_two), .fault_alarm_snapshot(fault_alarm_snapshot),
    .amp_mode(amp_mode), .int_fault_flag(int_fault_flag),
    .ext_fault_flag(ext_fault_flag), .dout_o(dout_o), .dout_oe(dout_oe));
  sfo_amp_model amp_u (.dout_o(dout_o), .dout_oe(dout_oe), .amp_mode(amp_mode),
    .pin_lvl(pin_lvl), .vout_kind(vout_kind));

  always #5 sys_clk = ~sys_clk;

  // ceiling well above the roughly 750 cycles the tests need
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_errors++;
      close_out();
    end
  end

  task close_out;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task cmp_word(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task cmp_bit(input logic got, input logic exp);
    cmp_word({15'h0000, got}, {15'h0000, exp});
  endtask

  task wr(input logic two, input logic [CFG_W-1:0] d);
    @(posedge sys_clk);
    config_word_one_wr <= ~two;
    config_word_two_wr <= two;
    config_word_one_wdata <= d;
    config_word_two_wdata <= d;
    @(posedge sys_clk);
    config_word_one_wr <= 1'b0;
    config_word_two_wr <= 1'b0;
    @(negedge sys_clk);
  endtask

  task settle;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task t_reset;
    cmp_word(config_word_two, 16'h0000);
    cmp_bit(dout_oe, 1'b0);
    cmp_bit(pin_lvl, 1'b1);
    cmp_word({13'h0000, amp_mode}, 16'h0000);
  endtask

  task t_pin;
    wr(1'b1, 16'h0180);
    cmp_bit(dout_oe, 1'b1);
    cmp_bit(pin_lvl, 1'b1);
    wr(1'b1, 16'h0100);
    cmp_bit(pin_lvl, 1'b0);
    wr(1'b1, 16'h0080);
    cmp_bit(dout_oe, 1'b0);
    @(posedge sys_clk);
    otp_config_word_two <= 16'h0180;
    otp_load <= 1'b1;
    @(posedge sys_clk);
    otp_load <= 1'b0;
    @(negedge sys_clk);
    cmp_word(config_word_two, 16'h0180);
    wr(1'b1, 16'h0100);
    cmp_word(config_word_two, 16'h0100);
  endtask

  task t_alarm;
    @(posedge sys_clk);
    comp_async <= 9'h155;
    settle;
    cmp_word(fault_alarm_snapshot, 16'h0155);
    @(posedge sys_clk);
    vout_enable <= 1'b0;
    @(posedge sys_clk);
    comp_async <= 9'h0AA;
    settle;
    cmp_word(fault_alarm_snapshot, 16'h0155);
    @(posedge sys_clk);
    vout_enable <= 1'b1;
    settle;
    cmp_word(fault_alarm_snapshot, 16'h00AA);
  endtask

  // every enable and level mix against none, edge-of-group and both faults
  task t_fault;
    logic [COMP_N-1:0] pats [4];
    logic [3:0] e;
    logic ef, inf, hit, lv;
    sfo_amp_mode_e m;
    logic [1:0] vk;
    pats = '{9'h000, 9'h020, 9'h040, 9'h181};
    for (int s = 0; s < 2; s++) begin
      wr(1'b1, {7'h00, s[0], 8'h00});
      for (int k = 0; k < 16; k++) begin
        e = k[3:0];
        wr(1'b0, {5'h00, e, 7'h00});
        for (int p = 0; p < 4; p++) begin
          @(posedge sys_clk);
          comp_async <= pats[p];
          over_lim_sel <= e[0];
          under_lim_sel <= e[1];
          settle;
          ef = |(pats[p] & EXT_MASK);
          inf = |(pats[p] & INT_MASK);
          hit = (ef & e[3]) | (inf & e[2]);
          lv = (ef & e[3]) ? e[1] : e[0];
          if (!hit) begin
            m = e[0] ? SFO_AMP_OVER_LIM : (e[1] ? SFO_AMP_UNDER_LIM : SFO_AMP_LINEAR);
            vk = 2'h3;
          end else if (lv == FAULT_LVL_HIGH) begin
            m = s[0] ? SFO_AMP_FAULT_RAIL : SFO_AMP_FAULT_CLAMP;
            vk = s[0] ? 2'h1 : 2'h2;
          end else begin
            m = SFO_AMP_FAULT_LOW;
            vk = 2'h0;
          end
          cmp_word({14'h0000, vout_kind}, {14'h0000, vk});
          cmp_word({13'h0000, amp_mode}, {13'h0000, m});
          cmp_bit(ext_fault_flag, ef);
          cmp_bit(int_fault_flag, inf);
          cmp_word(fault_alarm_snapshot, {7'h00, pats[p]});
        end
      end
    end
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    t_reset;
    t_pin;
    t_alarm;
    t_fault;
    close_out;
  end
endmodule
